// >>> gci_gain_ctrl.sv
// Gain registers, serial port, nibble port and interpolator timing
//
// Overview of operation
// - Six-bit receive code, -12..+48 dB through table
// - Receive gain resets to minimum, -12 dB
// - Receive reg: code 5:0, update enable bit 6
// - Nibble-port gain load only in full duplex
// - Strobe high, phase low: load nibble into gain
// - Strobe low routes nibbles to the interpolator
// - Bit 3 is a software strobe in full duplex
// - Bit 2 enables nibble-port gain, default on
// - Bit 1 selects three-bit half-duplex receive map
// - Gain port loads selected register without strobe
// - Bit 5 selects receive, bit 6 transmit
// - Transmit code gives 7.5 or 19.5 dB span
// - Converter map only with bit 0, four bits
// - Transmit reg: code 5:0, update enable bit 6
// - Transmit gain resets to zero, port routing off
// - Bits 7:6 pick factor four or two
// - Two half-band stages of 43 and 11 taps
// - Latency 21.5 words at two, 24 at four
`default_nettype none
module gci_gain_ctrl
    import gci_pkg::*;
#(
    parameter int DLY_DEPTH = LAT_X4_WORDS  // Interpolator delay line
)(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire gci_spi_in_t i_spi,
    input wire gci_txport_t i_txport,
    input wire logic [5:0] i_pga,
    input wire logic i_full_duplex,
    output logic o_spi_sdio_out,
    output logic o_spi_sdio_oe_n,
    output gci_rx_set_t o_rx_set,
    output logic [5:0] o_tx_atten,
    output logic o_tx_path_en,
    output logic [11:0] o_interp_word,
    output logic o_interp_valid,
    output logic o_interp_x2
);
    // ========================================================
    // Elaboration checks
    if (DLY_DEPTH < LAT_X4_WORDS)
    begin : g_chk
        $error("Delay line shorter than the four-times latency");
    end

    // ========================================================
    // State
    typedef struct packed {
        gci_pins_t s0;          // Pin synchroniser, first stage
        gci_pins_t s1;
        gci_pins_t s2;
        gci_pins_t f;           // Filtered pin levels
        logic [4:0] bit_cnt;    // Serial bits taken this frame
        logic rw;               // Frame is a read
        logic [6:0] addr;
        logic [7:0] shin;       // Serial input shifter
        logic [7:0] shout;      // Serial read-back shifter
        logic [5:0] rx_gain;
        logic rx_en;
        logic [5:0] tx_gain;
        logic tx_en;
        logic [7:0] route;
        logic [7:0] interp;
        logic [7:0] outsel;
        logic [5:0] msn;        // Held high nibble
        logic [DLY_DEPTH-1:0][11:0] dly;
        logic sdo;
        logic sdo_oe_n;
        gci_rx_set_t rx_set;
        logic [5:0] tx_atten;
        logic tx_path_en;
        logic [11:0] iword;
        logic ivalid;
        logic x2;
    } gci_state_t;

    // Reset image of the whole state
    function automatic gci_state_t rst_val();
        gci_state_t r;
        r = '0;
        r.s0.spi.sen_n = 1'b1;
        r.s1.spi.sen_n = 1'b1;
        r.s2.spi.sen_n = 1'b1;
        r.f.spi.sen_n = 1'b1;
        r.rx_gain = RX_GAIN_RST;
        r.tx_gain = TX_GAIN_RST;
        r.route = ROUTE_RST;
        r.interp = INTERP_RST;
        r.outsel = OUTSEL_RST;
        r.sdo_oe_n = 1'b1;
        r.tx_path_en = 1'b1;
        r.rx_set.db = -$signed(RX_DB_OFS);
        return r;
    endfunction
    localparam gci_state_t Q_RST = rst_val();

    // Receive table: code split over coarse and fine stages
    function automatic gci_rx_set_t rx_lut(input logic [5:0] code);
        logic [5:0] c;
        gci_rx_set_t r;
        c = (code > RX_CODE_MAX) ? RX_CODE_MAX : code;
        r.db = $signed({1'b0, c}) - $signed(RX_DB_OFS);
        r.coarse = 3'(c / RX_COARSE_STEP);
        r.fine = 4'(c % RX_COARSE_STEP);
        return r;
    endfunction

    // Level filter: a bit changes once stages two and three agree
    function automatic gci_pins_t filt(input gci_pins_t a,
                                       input gci_pins_t b,
                                       input gci_pins_t old);
        filt = (~(a ^ b) & b) | ((a ^ b) & old);
    endfunction

    gci_state_t q;
    gci_state_t n;
    logic rst_meta;
    logic rst_n;
    gci_pins_t pins;
    logic sclk_rise;
    logic sclk_fall;
    logic if_rise;
    logic strobe;
    logic link_load;
    logic word_push;
    logic spi_wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] tap;

    // ========================================================
    // Reset release, asserted at once, released over two edges
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ========================================================
    // Register read-back of applied values, gains only while enabled
    always_comb
    begin
        rdata = 8'h00;
        unique case (q.addr)
            // Gain reads only show data while the enable is set
            ADDR_RX_GAIN: rdata = q.rx_en ? {2'b01, q.rx_gain} : 8'h00;
            ADDR_TX_GAIN: rdata = q.tx_en ? {2'b01, q.tx_gain} : 8'h00;
            ADDR_ROUTE: rdata = q.route;
            ADDR_INTERP: rdata = q.interp;
            ADDR_OUTSEL: rdata = q.outsel;
            default: rdata = 8'h00;  // Unmapped reads as zero
        endcase
    end

    // ========================================================
    // Next state
    always_comb
    begin
        pins = '{spi: i_spi, tx: i_txport, pga: i_pga,
                 fdx: i_full_duplex};
        n = q;
        n.ivalid = 1'b0;
        n.s0 = pins;
        n.s1 = q.s0;
        n.s2 = q.s1;
        n.f = filt(q.s1, q.s2, q.f);
        sclk_rise = n.f.spi.sclk & ~q.f.spi.sclk;
        sclk_fall = ~n.f.spi.sclk & q.f.spi.sclk;
        if_rise = n.f.tx.clk & ~q.f.tx.clk;
        wdata = {q.shin[6:0], n.f.spi.sdio};
        spi_wr = 1'b0;
        link_load = 1'b0;
        word_push = 1'b0;

        // Gain port, lowest priority; copied on every cycle
        if (q.route[RT_RX_SEL])
        begin
            // Half duplex may use only three bits, in 8 dB steps
            if (q.route[RT_MAP3] && !q.f.fdx)
                n.rx_gain = {q.f.pga[2:0], 3'h0};
            else
                n.rx_gain = q.f.pga;
        end
        if (q.route[RT_TX_SEL])
            n.tx_gain = q.f.pga;

        // Nibble port on the rising edge of the interface clock
        strobe = q.f.fdx & (q.f.pga[5] | q.route[RT_SW_STROBE]);
        if (if_rise)
        begin
            if (strobe)
            begin
                // Strobed nibble goes to the gain, never the filter
                if (!n.f.tx.phase && q.route[RT_TXPORT_EN])
                begin
                    link_load = 1'b1;
                    n.rx_gain = n.f.tx.nib;
                end
            end
            else if (!n.f.tx.phase)
                n.msn = n.f.tx.nib;
            else
            begin
                word_push = 1'b1;
                n.dly = {q.dly[DLY_DEPTH-2:0], {q.msn, n.f.tx.nib}};
            end
        end

        // Serial port frame handling
        if (n.f.spi.sen_n)
        begin
            n.bit_cnt = 5'h00;
            n.sdo_oe_n = 1'b1;
        end
        else if (sclk_rise && q.bit_cnt != SPI_DONE)
        begin
            n.shin = wdata;
            n.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == SPI_HDR_LAST)
            begin
                n.rw = q.shin[6];
                n.addr = wdata[6:0];
            end
            if (q.bit_cnt == SPI_FRAME_LAST && !q.rw)
                spi_wr = 1'b1;
        end
        else if (sclk_fall && q.rw && q.bit_cnt[4:3] == 2'h1)
        begin
            // First falling edge after the address loads read data
            n.shout = (q.bit_cnt == SPI_HDR_LAST + 5'h01 && q.sdo_oe_n)
                      ? {rdata[6:0], 1'b0} : {q.shout[6:0], 1'b0};
            n.sdo = (q.bit_cnt == SPI_HDR_LAST + 5'h01 && q.sdo_oe_n)
                    ? rdata[7] : q.shout[7];
            n.sdo_oe_n = 1'b0;
        end

        // Serial writes win over both fast paths
        if (spi_wr)
        begin
            unique case (q.addr)
                ADDR_RX_GAIN:
                begin
                    n.rx_en = wdata[SPI_EN_BIT];
                    if (wdata[SPI_EN_BIT])
                        n.rx_gain = wdata[5:0];
                end
                ADDR_TX_GAIN:
                begin
                    n.tx_en = wdata[SPI_EN_BIT];
                    if (wdata[SPI_EN_BIT])
                        n.tx_gain = wdata[5:0];
                end
                ADDR_ROUTE: n.route = wdata;
                ADDR_INTERP: n.interp = wdata;
                ADDR_OUTSEL: n.outsel = wdata;
                default: n.route = q.route;  // Unmapped writes dropped
            endcase
        end

        // Registered outputs
        n.rx_set = rx_lut(n.rx_gain);
        if (n.outsel[OS_DAC_ONLY])
            n.tx_atten = {2'h0, n.tx_gain[3:0]};
        else
            n.tx_atten = (n.tx_gain > TX_AMP_MAX) ? TX_AMP_MAX : n.tx_gain;
        // A high shared bit in full duplex stalls the transmit path
        n.tx_path_en = ~(n.f.fdx & n.f.pga[5]);
        // Reserved factor codes fall back to four times
        n.x2 = (n.interp[IC_FACT_HI:IC_FACT_LO] == IC_FACT_X2);
        // Filter stages replaced by their pipeline delay, words late
        tap = n.x2 ? 5'(LAT_X2_WORDS) : 5'(LAT_X4_WORDS);
        if (word_push)
        begin
            n.ivalid = 1'b1;
            // Read before the shift, so the word is a full tap old
            n.iword = q.dly[tap - 5'h01];
        end
    end

    // ========================================================
    // State register, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= Q_RST;
        else if (i_ce)
            q <= n;
    end

    assign o_spi_sdio_out = q.sdo;
    assign o_spi_sdio_oe_n = q.sdo_oe_n;
    assign o_rx_set = q.rx_set;
    assign o_tx_atten = q.tx_atten;
    assign o_tx_path_en = q.tx_path_en;
    assign o_interp_word = q.iword;
    assign o_interp_valid = q.ivalid;
    assign o_interp_x2 = q.x2;

    // ========================================================
    // Assertions
    property p_rx_db;
        @(posedge i_clk) disable iff (!rst_n)
        q.rx_gain <= RX_CODE_MAX |->
            o_rx_set.db == $signed({1'b0, q.rx_gain}) - 7'sd12;
    endproperty
    a_rx_db: assert property (p_rx_db)
        else $error("Receive gain in dB does not follow the code");

    property p_rx_min;
        @(posedge i_clk) disable iff (!rst_n)
        $rose(rst_n) |-> q.rx_gain == 6'h00 && o_rx_set.db == -7'sd12;
    endproperty
    a_rx_min: assert property (p_rx_min)
        else $error("Receive gain not minimum after reset");

    property p_spi_rx;
        @(posedge i_clk) disable iff (!rst_n)
        i_ce && spi_wr && q.addr == ADDR_RX_GAIN && wdata[SPI_EN_BIT]
            && wdata[5:0] <= RX_CODE_MAX |=>
            q.rx_gain == $past(wdata[5:0]) &&
            o_rx_set.db == $signed({1'b0, $past(wdata[5:0])}) - 7'sd12;
    endproperty
    a_spi_rx: assert property (p_spi_rx)
        else $error("Serial receive gain write not applied");

    property p_link_load;
        @(posedge i_clk) disable iff (!rst_n)
        i_ce && link_load && !spi_wr |=>
            $past(q.f.fdx) && q.rx_gain == $past(n.f.tx.nib);
    endproperty
    a_link_load: assert property (p_link_load)
        else $error("Nibble-port gain load wrong");

    property p_word;
        @(posedge i_clk) disable iff (!rst_n)
        i_ce && word_push |-> !strobe ##1
            q.dly[0] == {$past(q.msn), $past(n.f.tx.nib)} && o_interp_valid;
    endproperty
    a_word: assert property (p_word)
        else $error("Nibble pair not routed to the interpolator");

    property p_pga_tx;
        @(posedge i_clk) disable iff (!rst_n)
        i_ce && q.route[6] && !spi_wr |=> q.tx_gain == $past(q.f.pga);
    endproperty
    a_pga_tx: assert property (p_pga_tx)
        else $error("Gain port did not reach the transmit gain");

    property p_tx_path;
        @(posedge i_clk) disable iff (!rst_n)
        i_ce && n.f.fdx && n.f.pga[5] |=> !o_tx_path_en;
    endproperty
    a_tx_path: assert property (p_tx_path)
        else $error("Transmit path left on with shared bit high");

    property p_dac_map;
        @(posedge i_clk) disable iff (!rst_n)
        q.outsel[0] |-> o_tx_atten == {2'h0, q.tx_gain[3:0]};
    endproperty
    a_dac_map: assert property (p_dac_map)
        else $error("Converter-only attenuation map wrong");
endmodule
`default_nettype wire

// >>> gci_pkg.sv
// Constants and carrier types for the gain control and interpolation block
`default_nettype none
package gci_pkg;
    // ========================================================
    // Register map (serial port addresses)
    localparam logic [6:0] ADDR_RX_GAIN = 7'h09;
    localparam logic [6:0] ADDR_TX_GAIN = 7'h0A;
    localparam logic [6:0] ADDR_ROUTE = 7'h0B;
    localparam logic [6:0] ADDR_INTERP = 7'h0C;
    localparam logic [6:0] ADDR_OUTSEL = 7'h0E;
    // ========================================================
    // Field positions
    localparam int SPI_EN_BIT = 6;    // Update enable in both gain regs
    localparam int RT_TX_SEL = 6;     // Gain port drives transmit gain
    localparam int RT_RX_SEL = 5;     // Gain port drives receive gain
    localparam int RT_SW_STROBE = 3;  // Software gain strobe
    localparam int RT_TXPORT_EN = 2;  // Receive gain via nibble port
    localparam int RT_MAP3 = 1;       // Three-bit mapping, half duplex
    localparam int OS_DAC_ONLY = 0;   // Converter output only
    localparam int IC_FACT_HI = 7;    // Interpolation factor field
    localparam int IC_FACT_LO = 6;
    localparam logic [1:0] IC_FACT_X4 = 2'h0;
    localparam logic [1:0] IC_FACT_X2 = 2'h1;
    // ========================================================
    // Reset values
    localparam logic [5:0] RX_GAIN_RST = 6'h00;  // Minimum gain
    localparam logic [5:0] TX_GAIN_RST = 6'h00;  // Minimum attenuation
    localparam logic [7:0] ROUTE_RST = 8'h04;    // Nibble-port load on
    localparam logic [7:0] INTERP_RST = 8'h00;   // Four times
    localparam logic [7:0] OUTSEL_RST = 8'h00;
    // ========================================================
    // Gain mapping
    localparam logic [5:0] RX_CODE_MAX = 6'h3C;  // Code for top gain
    localparam logic [6:0] RX_DB_OFS = 7'h0C;    // Code 0 is -12 dB
    localparam logic [5:0] RX_COARSE_STEP = 6'h0C;
    localparam logic [5:0] TX_AMP_MAX = 6'h27;   // 39 half-dB steps
    // ========================================================
    // Interpolator geometry and latency, in half input words
    localparam int STG1_TAPS = 43;
    localparam int STG2_TAPS = 11;
    localparam int LAT_X2_HALF = 43;
    localparam int LAT_X4_HALF = 48;
    localparam int LAT_X2_WORDS = (LAT_X2_HALF + 1) / 2;
    localparam int LAT_X4_WORDS = (LAT_X4_HALF + 1) / 2;
    // ========================================================
    // Serial frame: read flag, seven address bits, eight data bits
    localparam logic [4:0] SPI_HDR_LAST = 5'h07;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;
    localparam logic [4:0] SPI_DONE = 5'h10;
    // ========================================================
    // Carriers
    typedef struct packed {
        logic sclk;
        logic sen_n;
        logic sdio;
    } gci_spi_in_t;
    typedef struct packed {
        logic clk;        // Interface clock seen at the nibble port
        logic phase;      // tx_nibble_phase
        logic [5:0] nib;
    } gci_txport_t;
    typedef struct packed {
        gci_spi_in_t spi;
        gci_txport_t tx;
        logic [5:0] pga;  // parallel_gain_port, bit 5 shared strobe
        logic fdx;        // Full-duplex mode strap
    } gci_pins_t;
    typedef struct packed {
        logic signed [6:0] db;  // Applied receive gain in dB
        logic [2:0] coarse;     // Coarse stage setting
        logic [3:0] fine;       // Fine stage setting
    } gci_rx_set_t;
endpackage
`default_nettype wire

// >>> gci_asic_model.sv
// Baseband model driving the nibble port and its interface clock
`default_nettype none
module gci_asic_model
    import gci_pkg::*;
(
    output var gci_txport_t o_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Port state
    logic lclk = 1'b0;      // Interface clock, runs free
    logic ph = 1'b0;        // Nibble phase
    logic [5:0] nib = 6'h00;
    assign o_tx = {lclk, ph, nib};
    // Word rate 4 MSPS, far under the limit; every edge lags an i_clk edge by 0.5 ns
    initial
    begin
        #3;
        forever #62.5 lclk = ~lclk;
    end
    // ==========================================================
    // Word as two nibbles, high part while phase is low
    task automatic send_word(input logic [11:0] w);
        @(negedge lclk);
        ph = 1'b0;
        nib = w[11:6];
        @(negedge lclk);
        ph = 1'b1;
        nib = w[5:0];
    endtask
    // Gain nibble, held stable with phase low until the next call
    task automatic put_gain(input logic [5:0] g);
        @(negedge lclk);
        ph = 1'b0;
        nib = g;
    endtask
    // Idle: phase low, data flipped so a stale value never matches
    task automatic idle();
        @(negedge lclk);
        ph = 1'b0;
        nib = ~nib;
    endtask
endmodule
`default_nettype wire

// >>> gci_gain_ctrl_test.sv
// Self-checking bench for the gain control and interpolation block
`default_nettype none
module gci_gain_ctrl_test
    import gci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stimulus and observed signals
    logic i_clk, i_rstn, fdx, sclk, sen_n, sdo, sdo_en, dac, x2_mode;
    logic [5:0] pga, c, t, g, g2, g3, p;
    logic sdio_out, sdio_oe_n, tx_path_en, ivalid, ix2;
    logic [5:0] tx_atten;
    logic [11:0] iword;
    gci_rx_set_t rx_set;
    gci_txport_t tx;
    gci_spi_in_t spi;
    int miscompares = 0;
    int tests_run = 0;
    logic [11:0] exp_q[$];  // Words still due at the filter output
    logic [11:0] hist[$];   // Every word pushed so far
    // Shared data wire, pulled up when nobody drives it
    wire logic sdio_w = !sdio_oe_n ? sdio_out : (sdo_en ? sdo : 1'b1);
    assign spi = {sclk, sen_n, sdio_w};
    gci_asic_model U_ASIC (.o_tx(tx));
    gci_gain_ctrl #(.DLY_DEPTH(LAT_X4_WORDS)) DUT (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_spi(spi),
        .i_txport(tx), .i_pga(pga), .i_full_duplex(fdx),
        .o_spi_sdio_out(sdio_out), .o_spi_sdio_oe_n(sdio_oe_n),
        .o_rx_set(rx_set), .o_tx_atten(tx_atten),
        .o_tx_path_en(tx_path_en), .o_interp_word(iword),
        .o_interp_valid(ivalid), .o_interp_x2(ix2)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // ==========================================================
    // Expectations and comparison
    function automatic logic [13:0] exp_rx(input logic [5:0] v);
        logic [5:0] k;
        k = (v > RX_CODE_MAX) ? RX_CODE_MAX : v;
        return {7'({1'b0, k} - RX_DB_OFS), 3'(k / RX_COARSE_STEP),
                4'(k % RX_COARSE_STEP)};
    endfunction
    function automatic logic [5:0] exp_tx(input logic [5:0] v, input logic d);
        if (d)
            return {2'h0, v[3:0]};
        return (v > TX_AMP_MAX) ? TX_AMP_MAX : v;
    endfunction
    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] s);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // Serial frame: read flag, address, data; 8 cycles per level
    task automatic spi_x(input logic r, input logic [6:0] a,
                         input logic [7:0] wd, output logic [7:0] rv);
        logic [15:0] f;
        f = {r, a, wd};
        rv = 8'h00;
        sen_n = 1'b0;
        repeat (8) @(negedge i_clk);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            sdo_en = !(r && i < 8);  // Release for read data
            sdo = f[i];
            repeat (8) @(negedge i_clk);
            if (r && i < 8)
                rv[i] = sdio_w;
            sclk = 1'b1;
            repeat (8) @(negedge i_clk);
        end
        sclk = 1'b0;
        repeat (8) @(negedge i_clk);
        sen_n = 1'b1;
        sdo_en = 1'b1;
        repeat (8) @(negedge i_clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi_x(1'b0, a, d, x);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] x;
        spi_x(1'b1, a, 8'h00, x);
        check("register read", {8'h00, e}, {8'h00, x});
    endtask
    // Link periods plus the pin filter delay
    task automatic link_wait(input int n);
        repeat (n) @(negedge tx.clk);
        repeat (8) @(negedge i_clk);
    endtask
    task automatic strobe(input logic s);
        @(negedge i_clk);
        pga[5] = s;
        link_wait(2);
    endtask
    // Note the word due out now, then send this one
    task automatic word(input logic [11:0] w);
        int lat;
        lat = x2_mode ? LAT_X2_WORDS : LAT_X4_WORDS;
        exp_q.push_back(hist.size() >= lat ? hist[hist.size() - lat] : 12'h000);
        hist.push_back(w);
        U_ASIC.send_word(w);
    endtask
    // ==========================================================
    // Output watcher: every valid pulse takes the oldest note
    always @(negedge i_clk)
    begin
        if (ivalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("stray word", 16'h0000, 16'h0001);
            else
                check("word", {4'h0, exp_q.pop_front()}, {4'h0, iword});
        end
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #400_000;
        miscompares++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        i_rstn = 1'b0;
        {fdx, sclk, sdo, dac, x2_mode} = 5'h00;
        {sen_n, sdo_en} = 2'h3;
        pga = 6'h00;
        void'($urandom(74));
        repeat (3) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (10) @(negedge i_clk);
        check("rx reset", {2'h0, exp_rx(RX_GAIN_RST)}, {2'h0, rx_set});
        check("tx reset", {10'h000, TX_GAIN_RST}, {10'h000, tx_atten});
        check("path reset", 16'h0001, {15'h0000, tx_path_en});
        rd_chk(ADDR_RX_GAIN, 8'h00);
        rd_chk(ADDR_TX_GAIN, 8'h00);
        rd_chk(ADDR_ROUTE, ROUTE_RST);
        rd_chk(ADDR_INTERP, INTERP_RST);
        rd_chk(ADDR_OUTSEL, OUTSEL_RST);
        wr(7'h0D, 8'hFF);
        rd_chk(7'h0D, 8'h00);
        // Receive gain through the serial port, both range ends
        for (int k = 0; k < 6; k++)
        begin
            c = (k == 0) ? 6'h00 : (k == 1) ? RX_CODE_MAX
                : 6'($urandom_range(0, 60));
            wr(ADDR_RX_GAIN, {2'h1, c});
            check("rx gain", {2'h0, exp_rx(c)}, {2'h0, rx_set});
            rd_chk(ADDR_RX_GAIN, {2'h1, c});
        end
        wr(ADDR_RX_GAIN, {2'h0, ~c});
        check("rx held", {2'h0, exp_rx(c)}, {2'h0, rx_set});
        rd_chk(ADDR_RX_GAIN, 8'h00);
        wr(ADDR_RX_GAIN, {2'h1, c});
        // Transmit attenuation under both output mappings
        for (int m = 0; m < 8; m++)
        begin
            if (m[1:0] == 2'h0)
            begin
                dac = m[2];
                wr(ADDR_OUTSEL, {7'h00, dac});
                rd_chk(ADDR_OUTSEL, {7'h00, dac});
            end
            t = (m[1:0] == 2'h0) ? 6'h00 : (m[1:0] == 2'h1) ? TX_AMP_MAX
                : (m[1:0] == 2'h2) ? 6'h3F : 6'($urandom);
            wr(ADDR_TX_GAIN, {2'h1, t});
            check("tx atten", {10'h000, exp_tx(t, dac)}, {10'h000, tx_atten});
            rd_chk(ADDR_TX_GAIN, {2'h1, t});
        end
        // Every factor code, reserved ones included
        for (int f = 0; f < 4; f++)
        begin
            wr(ADDR_INTERP, 8'(f << 6));
            check("x2 flag", {15'h0000, f == 1}, {15'h0000, ix2});
            rd_chk(ADDR_INTERP, 8'(f << 6));
        end
        wr(ADDR_INTERP, 8'h00);
        // Word stream: four times, then two times mid-run
        for (int n = 0; n < 56; n++)
        begin
            if (n == 30)
            begin
                U_ASIC.idle();
                wr(ADDR_INTERP, 8'h40);
                x2_mode = 1'b1;
            end
            word(12'($urandom));
        end
        U_ASIC.idle();
        link_wait(4);
        // Gain from the nibble port, external strobe
        g = 6'($urandom_range(0, 60));
        g2 = 6'($urandom_range(0, 59));
        g3 = g2 + 6'h01;
        fdx = 1'b1;
        U_ASIC.put_gain(g);
        strobe(1'b1);
        check("path enable", 16'h0000, {15'h0000, tx_path_en});
        check("rx nibble", {2'h0, exp_rx(g)}, {2'h0, rx_set});
        rd_chk(ADDR_RX_GAIN, {2'h1, g});
        U_ASIC.send_word({g2, 6'h15});
        U_ASIC.put_gain(g2);
        strobe(1'b0);
        check("rx nibble", {2'h0, exp_rx(g2)}, {2'h0, rx_set});
        // Refused: half duplex, then nibble loading switched off; then loaded by the software strobe
        fdx = 1'b0;
        U_ASIC.put_gain(g3);
        strobe(1'b1);
        check("rx half", {2'h0, exp_rx(g2)}, {2'h0, rx_set});
        strobe(1'b0);
        wr(ADDR_ROUTE, 8'h00);
        fdx = 1'b1;
        strobe(1'b1);
        check("rx off", {2'h0, exp_rx(g2)}, {2'h0, rx_set});
        strobe(1'b0);
        wr(ADDR_ROUTE, 8'h0C);
        link_wait(2);
        check("rx soft", {2'h0, exp_rx(g3)}, {2'h0, rx_set});
        wr(ADDR_ROUTE, 8'h04);
        // Parallel gain port, with a safe switch-over to transmit
        fdx = 1'b0;
        p = 6'($urandom_range(0, 60));
        wr(ADDR_ROUTE, 8'h20);
        pga = p;
        repeat (8) @(negedge i_clk);
        check("rx port", {2'h0, exp_rx(p)}, {2'h0, rx_set});
        wr(ADDR_ROUTE, 8'h00);
        t = 6'($urandom);
        pga = t;
        wr(ADDR_ROUTE, 8'h40);
        check("tx port", {10'h000, exp_tx(t, dac)}, {10'h000, tx_atten});
        check("rx kept", {2'h0, exp_rx(p)}, {2'h0, rx_set});
        rd_chk(ADDR_TX_GAIN, {2'h1, t});
        wr(ADDR_ROUTE, 8'h22);
        pga = 6'($urandom);
        repeat (8) @(negedge i_clk);
        check("rx map3", {2'h0, exp_rx({pga[2:0], 3'h0})}, {2'h0, rx_set});
        wr(ADDR_ROUTE, ROUTE_RST);
        check("words left", 16'h0000, 16'(exp_q.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire
